// ---- sim/scp_host_model.sv ----
module scp_host_model (
  input  wire logic clk_sys,
  output logic      rxd,
  input  wire logic txd
);
  timeunit 1ns;
  timeprecision 1ps;

  int unsigned bit_cyc   = 10;
  int unsigned stop_errs = 0;
  logic [7:0]  got_q[$];

  // only the data line is driven; no flow-control lines exist
  initial rxd = 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // controller transmit: start, eight data lsb first, one stop, no parity
  task automatic send_byte(input logic [7:0] b, input bit good_stop);
    logic [9:0] f;
    f = {good_stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_sys);
      rxd = f[i];
      repeat (bit_cyc - 1) @(negedge clk_sys);
    end
    @(negedge clk_sys);
    rxd = 1'b1;
    if (!good_stop) repeat (2 * bit_cyc) @(negedge clk_sys);
  endtask

  // text is sent exactly as given, no spaces added around colons
  task automatic send_str(input string s);
    for (int i = 0; i < s.len(); i++) begin
      send_byte(s[i], 1'b1);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // controller receive, sampled mid bit
  always begin
    logic [7:0] d;
    @(negedge txd);
    repeat (bit_cyc / 2) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cyc) @(posedge clk_sys);
      d[i] = txd;
    end
    repeat (bit_cyc) @(posedge clk_sys);
    if (txd !== 1'b1) stop_errs++;
    got_q.push_back(d);
  end
endmodule

// ---- sim/scp_parser_properties.sv ----
module scp_parser_props #(
  parameter CLK_HZ = 100000000,
  parameter DEPTH  = 16
) (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       rxd,
  input wire logic       txd,
  input wire logic [2:0] baud_sel,
  input wire logic       cmd_valid,
  input wire logic [4:0] cmd_node,
  input wire logic       cmd_query,
  input wire logic       cmd_common,
  input wire logic       cmd_error,
  input wire logic       param_valid,
  input wire logic [7:0] param_byte,
  input wire logic       resp_valid,
  input wire logic       resp_ready,
  input wire logic [7:0] resp_data,
  input wire logic       rx_overrun
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence s_accept;
    resp_valid && resp_ready;
  endsequence
  sequence s_start_bit;
    ##2 !txd [*8];
  endsequence

  property p_tx_start;
    s_accept |-> s_start_bit;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("start bit missing");

  property p_tx_busy;
    s_accept |=> !resp_ready [*8];
  endproperty
  a_tx_busy: assert property (p_tx_busy) else $error("ready back too early");

  property p_tx_idle;
    resp_ready |-> txd;
  endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("txd low while idle");

  property p_valid_pulse;
    cmd_valid |=> !cmd_valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("command pulse too long");

  property p_err_pulse;
    cmd_error |=> !cmd_error;
  endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("error pulse too long");

  property p_exclusive;
    !(cmd_valid && cmd_error);
  endproperty
  a_exclusive: assert property (p_exclusive) else $error("command and error together");

  property p_common_idx;
    cmd_valid && cmd_common |-> cmd_node >= 5'h0D;
  endproperty
  a_common_idx: assert property (p_common_idx) else $error("common index wrong");

  property p_tree_idx;
    cmd_valid && !cmd_common |-> cmd_node inside {[5'h01:5'h0C]};
  endproperty
  a_tree_idx: assert property (p_tree_idx) else $error("tree index wrong");
endmodule

bind scp_parser scp_parser_props #(.CLK_HZ(CLK_HZ), .DEPTH(DEPTH)) scp_parser_props_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .rxd(rxd), .txd(txd), .baud_sel(baud_sel),
  .cmd_valid(cmd_valid), .cmd_node(cmd_node), .cmd_query(cmd_query),
  .cmd_common(cmd_common), .cmd_error(cmd_error), .param_valid(param_valid),
  .param_byte(param_byte), .resp_valid(resp_valid), .resp_ready(resp_ready),
  .resp_data(resp_data), .rx_overrun(rx_overrun)
);

// ---- sim/testbench.sv ----
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int HZ = 1152000;

  logic       clk_sys;
  logic       rst_n;
  logic       rxd;
  logic       txd;
  logic [2:0] baud_sel;
  logic       cmd_valid;
  logic [4:0] cmd_node;
  logic       cmd_query;
  logic       cmd_common;
  logic       cmd_error;
  logic       param_valid;
  logic [7:0] param_byte;
  logic       resp_valid;
  logic       resp_ready;
  logic [7:0] resp_data;
  logic       rx_overrun;
  logic [7:0] ev_q[$];
  logic [7:0] pv_q[$];
  int         ovr_cnt         = 0;
  int         failures        = 0;
  int         samples_checked = 0;
  int         cycles          = 0;

  scp_parser #(.CLK_HZ(HZ), .DEPTH(16)) scp_parser_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .rxd(rxd), .txd(txd), .baud_sel(baud_sel),
    .cmd_valid(cmd_valid), .cmd_node(cmd_node), .cmd_query(cmd_query),
    .cmd_common(cmd_common), .cmd_error(cmd_error), .param_valid(param_valid),
    .param_byte(param_byte), .resp_valid(resp_valid), .resp_ready(resp_ready),
    .resp_data(resp_data), .rx_overrun(rx_overrun)
  );

  scp_host_model scp_host_model_i (.clk_sys(clk_sys), .rxd(rxd), .txd(txd));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // event log: {0, common, query, node}, or FF for an error
  always @(negedge clk_sys) begin
    if (cmd_valid) ev_q.push_back({1'b0, cmd_common, cmd_query, cmd_node});
    if (cmd_error) ev_q.push_back(8'hFF);
    if (param_valid) pv_q.push_back(param_byte);
    if (rx_overrun) ovr_cnt++;
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 98000) begin
      failures++;
      $display("[ERR] %0t run did not finish", $time);
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // first expected event in the top byte
  task automatic expect_ev(input string m, input int n, input logic [31:0] exp);
    string lbl;
    lbl = m.substr(0, m.len() - 2);
    for (int k = 0; k < 400 && ev_q.size() < n; k++) @(negedge clk_sys);
    repeat (40) @(negedge clk_sys);
    check(8'(ev_q.size()), 8'(n), lbl);
    for (int i = 0; i < n; i++) begin
      check(ev_q.size() > i ? ev_q[i] : 8'hEE, exp[31-8*i -: 8], lbl);
    end
  endtask

  task automatic run_msg(input string m, input int n, input logic [31:0] exp);
    ev_q.delete();
    pv_q.delete();
    scp_host_model_i.send_str(m);
    expect_ev(m, n, exp);
  endtask

  task automatic send_resp(input string s);
    int k;
    resp_valid = 1'b1;
    for (int i = 0; i < s.len(); i++) begin
      resp_data = s[i];
      k = 0;
      while (!resp_ready && k < 2000) begin
        @(negedge clk_sys);
        k++;
      end
      @(negedge clk_sys);
    end
    resp_valid = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_query_forms();
    run_msg("func?\n", 1, {8'h24, 24'h0});
    run_msg("FuncTion?\n", 1, {8'h24, 24'h0});
    $display("done query_forms");
  endtask

  task automatic t_tree_path();
    string p = "cp-d4";
    run_msg("func:imp:type cp-d;rang 4\n", 2, {8'h08, 8'h07, 16'h0});
    check(8'(pv_q.size()), 8'h05, "param count");
    for (int i = 0; i < 5; i++) begin
      check(pv_q.size() > i ? pv_q[i] : 8'hEE, p[i], "param byte");
    end
    run_msg("abcdefghijklm;func:imp:auto:x;;*idn:1\n", 3, {8'hFF, 8'hFF, 8'hFF, 8'h0});
    run_msg("func:imp:rang 2;page?\n", 2, {8'h07, 8'hFF, 16'h0});
    run_msg("page?\n", 1, {8'hFF, 24'h0});
    run_msg("bogus 3;freq?\n", 2, {8'hFF, 8'h29, 16'h0});
    $display("done tree_path");
  endtask

  task automatic t_root();
    run_msg("func:imp:rang 2; :disp:page?\n", 2, {8'h07, 8'h23, 16'h0});
    $display("done root");
  endtask

  task automatic t_common();
    run_msg("func:imp:rang 8;*IDN?;auto on\n", 3, {8'h07, 8'h6E, 8'h06, 8'h0});
    run_msg("*sav 1;*rcl 1\n", 2, {8'h4F, 8'h50, 16'h0});
    $display("done common");
  endtask

  task automatic t_abbrev();
    string      am[8] = '{"disp:line x\n", "comp:ptolerance?\n", "comp:ptol?\n",
                          "func:impedance:auto?\n", "FUNC:IMP:RANGE?\n", "frequency?\n",
                          "freq 1e3\n", "COMPARATOR\n"};
    logic [7:0] ae[8] = '{8'h02, 8'h2C, 8'h2C, 8'h26, 8'h27, 8'h29, 8'h09, 8'h0B};
    for (int i = 0; i < 8; i++) begin
      run_msg(am[i], 1, {ae[i], 24'h0});
    end
    run_msg("func:impe?\n", 1, {8'hFF, 24'h0});
    $display("done abbrev");
  endtask

  task automatic t_frame();
    ev_q.delete();
    scp_host_model_i.send_str("func");
    scp_host_model_i.send_byte(8'h58, 1'b0);
    scp_host_model_i.send_str("?\n");
    expect_ev("func?\n", 1, {8'h24, 24'h0});
    check(8'(ovr_cnt), 8'h00, "overrun pulses");
    $display("done frame");
  endtask

  task automatic t_resp();
    string s;
    logic [7:0] r;
    s = "SYST\n";
    run_msg("disp:page?\n", 1, {8'h23, 24'h0});
    scp_host_model_i.got_q.delete();
    send_resp(s);
    for (int k = 0; k < 1000 && scp_host_model_i.got_q.size() < 5; k++) @(negedge clk_sys);
    check(8'(scp_host_model_i.got_q.size()), 8'h05, "reply count");
    for (int i = 0; i < 5; i++) begin
      r = scp_host_model_i.got_q.size() > i ? scp_host_model_i.got_q[i] : 8'hEE;
      check(r, s[i], "reply byte");
    end
    check(8'(scp_host_model_i.stop_errs), 8'h00, "reply stop bit");
    $display("done resp");
  endtask

  task automatic t_baud();
    int rates[5] = '{1200, 9600, 38400, 57600, 115200};
    for (int s = 0; s < 5; s++) begin
      baud_sel = s[2:0];
      scp_host_model_i.bit_cyc = HZ / rates[s];
      run_msg("*trg\n", 1, {8'h4D, 24'h0});
    end
    $display("done baud");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n      = 1'b0;
    baud_sel   = 3'h4;
    resp_valid = 1'b0;
    resp_data  = 8'h00;
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    t_query_forms();
    t_tree_path();
    t_root();
    t_common();
    t_abbrev();
    t_frame();
    t_resp();
    t_baud();
    wrap_up();
  end
endmodule

// ---- src/scp_map.vh ----
`ifndef SCP_MAP_VH
`define SCP_MAP_VH

// character codes the parser reacts to
`define SCP_CHR_LF      8'h0A
`define SCP_CHR_SPACE   8'h20
`define SCP_CHR_STAR    8'h2A
`define SCP_CHR_COLON   8'h3A
`define SCP_CHR_SEMI    8'h3B
`define SCP_CHR_QMARK   8'h3F

// serial frame shape
`define SCP_DATA_BITS   8
`define SCP_STOP_BITS   1
`define SCP_FRAME_BITS  4'hA

// selectable bit rates, in baud
`define SCP_BAUD_1200   1200
`define SCP_BAUD_9600   9600
`define SCP_BAUD_38400  38400
`define SCP_BAUD_57600  57600
`define SCP_BAUD_115200 115200

// baud_sel encodings
`define SCP_SEL_1200    3'h0
`define SCP_SEL_9600    3'h1
`define SCP_SEL_38400   3'h2
`define SCP_SEL_57600   3'h3
`define SCP_SEL_115200  3'h4

// system clock rate in Hz
`define SCP_CLK_HZ      100000000

// keyword store and table
`define SCP_KW_MAX      4'hC
`define SCP_KW_COUNT    5'h10
`define SCP_MAX_DEPTH   2'h2

`endif

// ---- src/scp_parser.v ----
`include "scp_map.vh"

////////////////////////////////////////////////////////////////////////////////
// receive byte buffer
module scp_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk_sys,
  input  wire             rst_n,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  assign in_ready  = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////////
module scp_parser #(
  parameter CLK_HZ = `SCP_CLK_HZ,
  parameter DEPTH  = 16
) (
  input  wire       clk_sys,
  input  wire       rst_n,
  input  wire       rxd,
  output reg        txd,
  input  wire [2:0] baud_sel,
  output reg        cmd_valid,
  output reg  [4:0] cmd_node,
  output reg        cmd_query,
  output reg        cmd_common,
  output reg        cmd_error,
  output reg        param_valid,
  output reg  [7:0] param_byte,
  input  wire       resp_valid,
  output wire       resp_ready,
  input  wire [7:0] resp_data,
  output reg        rx_overrun
);
  localparam RX_IDLE  = 4'b0001;
  localparam RX_START = 4'b0010;
  localparam RX_DATA  = 4'b0100;
  localparam RX_STOP  = 4'b1000;
  localparam TX_IDLE  = 2'b01;
  localparam TX_RUN   = 2'b10;
  localparam ST_HEAD  = 5'b00001;
  localparam ST_MATCH = 5'b00010;
  localparam ST_PARAM = 5'b00100;
  localparam ST_SKIP  = 5'b01000;
  localparam ST_DONE  = 5'b10000;

  // one table entry: {common, parent, long length, long form left-justified}
  function [105:0] kw_entry;
    input [4:0] i;
    begin
      case (i)
        5'h01: kw_entry = {1'b0, 5'h00, 4'h7, "DISPLAY", 40'h0};
        5'h02: kw_entry = {1'b0, 5'h01, 4'h4, "LINE", 64'h0};
        5'h03: kw_entry = {1'b0, 5'h01, 4'h4, "PAGE", 64'h0};
        5'h04: kw_entry = {1'b0, 5'h00, 4'h8, "FUNCTION", 32'h0};
        5'h05: kw_entry = {1'b0, 5'h04, 4'h9, "IMPEDANCE", 24'h0};
        5'h06: kw_entry = {1'b0, 5'h05, 4'h4, "AUTO", 64'h0};
        5'h07: kw_entry = {1'b0, 5'h05, 4'h5, "RANGE", 56'h0};
        5'h08: kw_entry = {1'b0, 5'h05, 4'h4, "TYPE", 64'h0};
        5'h09: kw_entry = {1'b0, 5'h00, 4'h9, "FREQUENCY", 24'h0};
        5'h0A: kw_entry = {1'b0, 5'h04, 4'h5, "RANGE", 56'h0};
        5'h0B: kw_entry = {1'b0, 5'h00, 4'hA, "COMPARATOR", 16'h0};
        5'h0C: kw_entry = {1'b0, 5'h0B, 4'hA, "PTOLERANCE", 16'h0};
        5'h0D: kw_entry = {1'b1, 5'h00, 4'h3, "TRG", 72'h0};
        5'h0E: kw_entry = {1'b1, 5'h00, 4'h3, "IDN", 72'h0};
        5'h0F: kw_entry = {1'b1, 5'h00, 4'h3, "SAV", 72'h0};
        5'h10: kw_entry = {1'b1, 5'h00, 4'h3, "RCL", 72'h0};
        default: kw_entry = 106'h0;
      endcase
    end
  endfunction

  function is_vowel;
    input [7:0] c;
    begin
      is_vowel = (c == "A") || (c == "E") || (c == "I") || (c == "O") || (c == "U");
    end
  endfunction

  function [3:0] short_len;
    input [3:0] l;
    input [7:0] c4;
    begin
      if (l <= 4'h4) begin
        short_len = l;
      end else if (is_vowel(c4)) begin
        short_len = 4'h3;
      end else begin
        short_len = 4'h4;
      end
    end
  endfunction

  // bit period in clocks for the selected rate
  function [16:0] baud_div;
    input [2:0] sel;
    reg   [31:0] d;
    begin
      case (sel)
        `SCP_SEL_1200:  d = CLK_HZ / `SCP_BAUD_1200;
        `SCP_SEL_9600:  d = CLK_HZ / `SCP_BAUD_9600;
        `SCP_SEL_38400: d = CLK_HZ / `SCP_BAUD_38400;
        `SCP_SEL_57600: d = CLK_HZ / `SCP_BAUD_57600;
        default:        d = CLK_HZ / `SCP_BAUD_115200;
      endcase
      baud_div = d[16:0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // receiver: rxd is the only input pin, no flow control exists
  reg        rx_s1;
  reg        rx_s2;
  reg        rx_s3;
  reg        rx_lvl;
  reg [3:0]  rx_state;
  reg [16:0] rx_cnt;
  reg [2:0]  rx_bit;
  reg [7:0]  rx_sh;
  reg        rx_wr;
  reg [7:0]  rx_byte;
  wire [16:0] div = baud_div(baud_sel);
  wire        fifo_in_ready;
  wire        fifo_valid;
  wire [7:0]  fifo_data;
  wire        fifo_ready;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_s1      <= 1'b1;
      rx_s2      <= 1'b1;
      rx_s3      <= 1'b1;
      rx_lvl     <= 1'b1;
      rx_state   <= RX_IDLE;
      rx_cnt     <= 17'h00000;
      rx_bit     <= 3'h0;
      rx_sh      <= 8'h00;
      rx_wr      <= 1'b0;
      rx_byte    <= 8'h00;
      rx_overrun <= 1'b0;
    end else begin
      rx_s1      <= rxd;
      rx_s2      <= rx_s1;
      rx_s3      <= rx_s2;
      rx_wr      <= 1'b0;
      rx_overrun <= rx_wr & ~fifo_in_ready;
      if (rx_s2 == rx_s3) begin
        rx_lvl <= rx_s3;
      end
      case (rx_state)
        RX_IDLE: begin
          if (!rx_lvl) begin
            rx_cnt   <= {1'b0, div[16:1]};
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (rx_cnt != 17'h00000) begin
            rx_cnt <= rx_cnt - 17'h00001;
          end else if (!rx_lvl) begin
            rx_cnt   <= div - 17'h00001;
            rx_bit   <= 3'h0;
            rx_state <= RX_DATA;
          end else begin
            rx_state <= RX_IDLE;
          end
        end
        RX_DATA: begin
          if (rx_cnt != 17'h00000) begin
            rx_cnt <= rx_cnt - 17'h00001;
          end else begin
            rx_sh  <= {rx_lvl, rx_sh[7:1]};
            rx_cnt <= div - 17'h00001;
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == 3'h7) begin
              rx_state <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_cnt != 17'h00000) begin
            rx_cnt <= rx_cnt - 17'h00001;
          end else begin
            rx_wr    <= rx_lvl;
            rx_byte  <= rx_sh;
            rx_state <= RX_IDLE;
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  scp_fifo #(
    .WIDTH (8),
    .DEPTH (DEPTH),
    .AW    (4)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (rx_wr),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_byte),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready),
    .out_data  (fifo_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // transmitter for query responses
  reg [1:0]  tx_state;
  reg [9:0]  tx_sh;
  reg [3:0]  tx_n;
  reg [16:0] tx_cnt;

  assign resp_ready = (tx_state == TX_IDLE);

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      txd      <= 1'b1;
      tx_state <= TX_IDLE;
      tx_sh    <= 10'h3FF;
      tx_n     <= 4'h0;
      tx_cnt   <= 17'h00000;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          if (resp_valid) begin
            tx_sh    <= {1'b1, resp_data, 1'b0};
            tx_n     <= `SCP_FRAME_BITS;
            tx_cnt   <= 17'h00000;
            tx_state <= TX_RUN;
          end
        end
        TX_RUN: begin
          if (tx_cnt != 17'h00000) begin
            tx_cnt <= tx_cnt - 17'h00001;
          end else if (tx_n == 4'h0) begin
            tx_state <= TX_IDLE;
          end else begin
            txd    <= tx_sh[0];
            tx_sh  <= {1'b1, tx_sh[9:1]};
            tx_n   <= tx_n - 4'h1;
            tx_cnt <= div - 17'h00001;
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // header parser
  reg [4:0]  p_state;
  reg [7:0]  kw_buf [0:11];
  reg [3:0]  kw_len;
  reg [7:0]  kw_term;
  reg        kw_common;
  reg        kw_ovf;
  reg [4:0]  base;
  reg [4:0]  cur;
  reg [4:0]  leaf_par;
  reg [1:0]  depth;
  reg [4:0]  m_idx;
  reg        q;
  reg        ch_eq;
  integer    i;
  wire [105:0] ent   = kw_entry(m_idx);
  wire [3:0]   s_len = short_len(ent[99:96], ent[71:64]);
  wire [7:0]   c     = fifo_data;
  wire [7:0]   up    = ((c >= "a") && (c <= "z")) ? c - 8'h20 : c;
  wire         is_sep = (c == `SCP_CHR_COLON) || (c == `SCP_CHR_QMARK) ||
                        (c == `SCP_CHR_SPACE) || (c == `SCP_CHR_SEMI) || (c == `SCP_CHR_LF);
  wire         hit;

  assign fifo_ready = (p_state == ST_HEAD) || (p_state == ST_PARAM) || (p_state == ST_SKIP);

  always @* begin
    ch_eq = 1'b1;
    for (i = 0; i < 12; i = i + 1) begin
      if ((i < kw_len) && (kw_buf[i] != ent[95-8*i -: 8])) begin
        ch_eq = 1'b0;
      end
    end
  end

  assign hit = (kw_len != 4'h0) && !kw_ovf && ch_eq &&
               ((kw_len == ent[99:96]) || (kw_len == s_len)) &&
               (ent[105] == kw_common) &&
               (kw_common || (ent[104:100] == cur));

  // end of one command at a separator or the terminator
  task close_cmd;
    input [7:0] t;
    input       emit;
    input       err;
    begin
      cmd_valid <= emit;
      cmd_error <= err;
      cmd_query <= q;
      kw_len    <= 4'h0;
      kw_common <= 1'b0;
      kw_ovf    <= 1'b0;
      depth     <= 2'h0;
      q         <= 1'b0;
      if (t == `SCP_CHR_LF) begin
        base    <= 5'h00;
        cur     <= 5'h00;
        p_state <= ST_HEAD;
      end else if (t == `SCP_CHR_SEMI) begin
        base    <= (emit && !cmd_common) ? leaf_par : base;
        cur     <= (emit && !cmd_common) ? leaf_par : base;
        p_state <= ST_HEAD;
      end else begin
        p_state <= ST_SKIP;
      end
    end
  endtask

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      p_state     <= ST_HEAD;
      kw_len      <= 4'h0;
      kw_term     <= 8'h00;
      kw_common   <= 1'b0;
      kw_ovf      <= 1'b0;
      base        <= 5'h00;
      cur         <= 5'h00;
      leaf_par    <= 5'h00;
      depth       <= 2'h0;
      m_idx       <= 5'h01;
      q           <= 1'b0;
      cmd_valid   <= 1'b0;
      cmd_node    <= 5'h00;
      cmd_query   <= 1'b0;
      cmd_common  <= 1'b0;
      cmd_error   <= 1'b0;
      param_valid <= 1'b0;
      param_byte  <= 8'h00;
    end else begin
      cmd_valid   <= 1'b0;
      cmd_error   <= 1'b0;
      param_valid <= 1'b0;
      case (p_state)
        ST_HEAD: begin
          if (fifo_valid) begin
            if ((c == `SCP_CHR_COLON) && (kw_len == 4'h0) && (depth == 2'h0) && !kw_common) begin
              base <= 5'h00;
              cur  <= 5'h00;
            end else if ((c == `SCP_CHR_STAR) && (kw_len == 4'h0) && (depth == 2'h0)) begin
              kw_common <= 1'b1;
            end else if ((c == `SCP_CHR_SPACE) && (kw_len == 4'h0) && (depth == 2'h0)) begin
              kw_len <= 4'h0;
            end else if (is_sep && (kw_len == 4'h0)) begin
              close_cmd(c, 1'b0, (c != `SCP_CHR_SEMI) && (c != `SCP_CHR_LF));
            end else if (is_sep) begin
              kw_term <= c;
              m_idx   <= 5'h01;
              p_state <= ST_MATCH;
            end else if (kw_len == `SCP_KW_MAX) begin
              kw_ovf <= 1'b1;
            end else begin
              kw_buf[kw_len] <= up;
              kw_len         <= kw_len + 4'h1;
            end
          end
        end
        ST_MATCH: begin
          if (hit) begin
            cmd_node   <= m_idx;
            cmd_common <= kw_common;
            kw_len     <= 4'h0;
            if (!kw_common) begin
              leaf_par <= cur;
              cur      <= m_idx;
            end
            case (kw_term)
              `SCP_CHR_COLON: begin
                if (kw_common || (depth == `SCP_MAX_DEPTH)) begin
                  close_cmd(kw_term, 1'b0, 1'b1);
                end else begin
                  depth   <= depth + 2'h1;
                  p_state <= ST_HEAD;
                end
              end
              `SCP_CHR_QMARK: begin
                q       <= 1'b1;
                p_state <= ST_PARAM;
              end
              `SCP_CHR_SPACE: p_state <= ST_PARAM;
              default:        p_state <= ST_DONE;
            endcase
          end else if (m_idx == `SCP_KW_COUNT) begin
            close_cmd(kw_term, 1'b0, 1'b1);
          end else begin
            m_idx <= m_idx + 5'h01;
          end
        end
        ST_DONE: begin
          close_cmd(kw_term, 1'b1, 1'b0);
        end
        ST_PARAM: begin
          if (fifo_valid) begin
            if ((c == `SCP_CHR_SEMI) || (c == `SCP_CHR_LF)) begin
              close_cmd(c, 1'b1, 1'b0);
            end else begin
              param_valid <= 1'b1;
              param_byte  <= c;
            end
          end
        end
        ST_SKIP: begin
          if (fifo_valid && ((c == `SCP_CHR_SEMI) || (c == `SCP_CHR_LF))) begin
            close_cmd(c, 1'b0, 1'b0);
          end
        end
        default: p_state <= ST_HEAD;
      endcase
    end
  end
endmodule
